// >>> design/oic_consts.svh
// Constants of the output interface control block: offsets, reset
// values and timing counts. Included by the package and the design.
`ifndef OIC_CONSTS_SVH
`define OIC_CONSTS_SVH
// Register byte offsets on the bus
`define OIC_ADR_CTRL   8'h00
`define OIC_ADR_STAT   8'h04
// Control word reset value and width
`define OIC_CTRL_RST   26'h0000000
`define OIC_CTRL_W     26
// Idle SENT bus longer than this many ticks resyncs the slot counter
`define OIC_IDLE_TICKS 10'h1ff
// Number of the SPI clock edge that may be skipped
`define OIC_SKIP_EDGE  5'h11
// SENT variant codes
`define OIC_SENT_OFF   4'h0
`define OIC_SSENT_A    4'h6
`define OIC_SSENT_B    4'h7
// System clock rate in Hz
`define OIC_CLK_HZ     200000000
// Duty resolution in bits
`define OIC_DUTY_BITS  8
`endif

// >>> design/oic_pkg.sv
// Types of the output interface control block.
// Assumes oic_consts.svh is on the include path.
`include "oic_consts.svh"
package oic_pkg;
	// Control word, bit 25 first
	typedef struct packed {
		logic [1:0] pulse_adj;
		logic       pwm_enable;
		logic [2:0] pwm_band;
		logic [3:0] pwm_freq_sel;
		logic       rsvd;
		logic       out_hyst_en;
		logic       err_out_en;
		logic       err_style;
		logic       lin_enable;
		logic       correction_range;
		logic       zero_after_lin;
		logic       idle_slot_resync;
		logic       reset_offline_hold;
		logic [2:0] fall_slew;
		logic       manchester_ignore;
		logic       hyst_to_turn_count;
		logic       skip_extra_spi_edge;
		logic       rx_crc_check;
	} oic_ctrl_t;
	// Owner of the shared output pin
	typedef enum logic [1:0] {
		mode_spi  = 2'h0,
		mode_sent = 2'h1,
		mode_pwm  = 2'h3
	} oic_mode_t;
	// Incoming SPI packet, already checked for CRC
	typedef struct packed {
		logic       valid;
		logic       crc_ok;
		logic       is_read;
		logic [5:0] addr;
	} oic_pkt_t;
	// Carrier frequency in Hz, index {band, freq select}
	localparam logic [11:0] oic_pwm_hz [0:127] = '{
	12'd3125,12'd3101,12'd3077,12'd3053,12'd3030,12'd3008,12'd2985,12'd2963,
	12'd2941,12'd2920,12'd2899,12'd2878,12'd2857,12'd2837,12'd2817,12'd2797,
	12'd2778,12'd2740,12'd2703,12'd2667,12'd2632,12'd2597,12'd2564,12'd2532,
	12'd2500,12'd2469,12'd2439,12'd2410,12'd2381,12'd2353,12'd2326,12'd2299,
	12'd2273,12'd2222,12'd2174,12'd2128,12'd2083,12'd2041,12'd2000,12'd1961,
	12'd1923,12'd1887,12'd1852,12'd1818,12'd1786,12'd1754,12'd1724,12'd1695,
	12'd1667,12'd1613,12'd1563,12'd1515,12'd1471,12'd1429,12'd1389,12'd1351,
	12'd1316,12'd1282,12'd1250,12'd1220,12'd1190,12'd1163,12'd1136,12'd1111,
	12'd1087,12'd1042,12'd1000,12'd962,12'd926,12'd893,12'd862,12'd833,
	12'd806,12'd781,12'd758,12'd735,12'd714,12'd694,12'd676,12'd658,
	12'd641,12'd610,12'd581,12'd556,12'd532,12'd510,12'd490,12'd472,
	12'd455,12'd439,12'd424,12'd410,12'd397,12'd385,12'd373,12'd362,
	12'd352,12'd333,12'd316,12'd301,12'd287,12'd275,12'd263,12'd253,
	12'd243,12'd234,12'd225,12'd217,12'd210,12'd203,12'd197,12'd191,
	12'd185,12'd175,12'd166,12'd157,12'd150,12'd143,12'd137,12'd131,
	12'd126,12'd121,12'd116,12'd112,12'd108,12'd105,12'd101,12'd98
	};
endpackage

// >>> design/oic_top.sv
// Output interface control word with the logic it steers: pin owner,
// PWM carrier, error response, angle path, SENT slots, SPI options.
// Assumes one clock; pins arrive asynchronously, the rest on clk.
`timescale 1ns/1ps
`include "oic_consts.svh"

module oic_top #(
	parameter int CLK_HZ = `OIC_CLK_HZ,
	parameter int N_ERR  = 8
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  resetn,
	// Wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// Shadow load of the control word
	input  wire logic                  cfg_load,
	input  wire logic [25:0]           cfg_word,
	// Angle path
	input  wire logic [13:0]           angle_raw,
	input  wire logic [13:0]           pll_angle,
	input  wire logic [13:0]           zcd_angle,
	input  wire logic                  turns_use_pll,
	input  wire logic [5:0]            hyst_thr,
	input  wire logic [11:0]           zero_offset,
	input  wire logic [10:0]           lin_corr,
	// SENT side
	input  wire logic [3:0]            sent_variant,
	input  wire logic                  sent_tx,
	input  wire logic                  sent_tick,
	input  wire logic                  sent_bus_pin,
	input  wire logic                  sync_pulse,
	input  wire logic                  slot_sync,
	input  wire logic                  slot_mark_en,
	input  wire logic                  slot_advance,
	// Errors, index 0 has the highest priority
	input  wire logic [N_ERR-1:0]      err_flags,
	input  wire logic [8*N_ERR-1:0]    err_duty,
	// SPI side
	input  wire logic                  spi_dout,
	input  wire logic                  spi_dout_en,
	input  wire logic                  spi_sclk_pin,
	input  wire logic                  spi_csn_pin,
	input  wire oic_pkg::oic_pkt_t     pkt,
	// Manchester commands on the supply line
	input  wire logic                  man_cmd_valid,
	// Shared output pin
	output logic                       miso_o,
	output logic                       miso_oe,
	// Steering outputs
	output logic                       sent_en,
	output logic      [2:0]            sent_slew,
	output logic                       lin_active,
	output logic      [13:0]           out_angle,
	output logic      [13:0]           turns_angle,
	output logic      [13:0]           turns_in,
	output logic                       online,
	output logic      [3:0]            slot_cnt,
	output logic                       man_cmd_accept,
	output logic                       spi_bit_strobe,
	output logic                       pkt_accept,
	output logic      [5:0]            resp_addr
);
	initial begin
		if (CLK_HZ < 8192 || CLK_HZ > 1000000000 || N_ERR < 1)
			$error("oic_top: parameter out of range");
	end

	// Hold the old angle until the new one moves past the threshold
	function automatic logic [13:0] hyst_step(input logic [13:0] held,
			input logic [13:0] now, input logic [5:0] thr);
		logic [13:0] d;
		d = now - held;
		if (d[13])
			d = 14'h0 - d;
		return (d > {8'h00, thr}) ? now : held;
	endfunction

	// Merge write data into a word by byte lanes
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	oic_pkg::oic_ctrl_t ctrl;
	oic_pkg::oic_mode_t out_mode;
	oic_pkg::oic_mode_t next_mode;
	logic [31:0] next_ctrl;
	logic        hit;
	logic        err_any;
	logic        err_tri;
	logic        err_halve;
	logic [7:0]  err_code;
	logic        sent_on;
	logic        shared_bus;

	// Bus handshake: answer one cycle after the request
	assign hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_ff @(posedge clk) begin
		if (!resetn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= hit;
	end

	// Control word; a bus write in the same cycle beats a shadow load
	always_comb begin
		next_ctrl = lane_merge({6'h00, ctrl}, wb_dat_i, wb_sel_i);
	end
	always_ff @(posedge clk) begin
		if (!resetn)
			ctrl <= `OIC_CTRL_RST;
		else if (hit && wb_we_i && wb_adr_i == `OIC_ADR_CTRL)
			ctrl <= next_ctrl[25:0];
		else if (cfg_load)
			ctrl <= cfg_word;
	end

	// Read data; unmapped offsets read as zero
	logic [7:0] drop_cnt;
	always_ff @(posedge clk) begin
		if (!resetn)
			wb_dat_o <= 32'h0;
		else if (hit && !wb_we_i) begin
			case (wb_adr_i)
			`OIC_ADR_CTRL: wb_dat_o <= {6'h00, ctrl};
			`OIC_ADR_STAT: wb_dat_o <= {16'h0000, drop_cnt, slot_cnt,
				online, err_any, out_mode};
			default:       wb_dat_o <= 32'h0;
			endcase
		end
	end

	// Error response; gated off entirely when error output is off
	always_comb begin
		err_any  = |err_flags;
		err_code = 8'h00;
		for (int i = N_ERR - 1; i >= 0; i--)
			if (err_flags[i])
				err_code = err_duty[8*i +: 8];
	end
	assign err_tri   = ctrl.err_out_en && !ctrl.err_style && err_any;
	assign err_halve = ctrl.err_out_en && ctrl.err_style && err_any;

	// Pin owner from the enable bit and the SENT variant
	assign sent_on    = sent_variant != `OIC_SENT_OFF;
	assign shared_bus = sent_variant == `OIC_SSENT_A ||
		sent_variant == `OIC_SSENT_B;
	always_comb begin
		if (ctrl.pwm_enable)
			next_mode = oic_pkg::mode_pwm;
		else if (sent_on)
			next_mode = oic_pkg::mode_sent;
		else
			next_mode = oic_pkg::mode_spi;
	end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_mode  <= oic_pkg::mode_spi;
			sent_en   <= 1'b0;
			sent_slew <= 3'h0;
		end else begin
			out_mode  <= next_mode;
			sent_en   <= !ctrl.pwm_enable && sent_on;
			sent_slew <= ctrl.fall_slew;
		end
	end

	// Angle path: offset, linearization, hysteresis
	logic [13:0] off14;
	logic [13:0] corr14;
	logic [13:0] pre_lin;
	logic [13:0] post_lin;
	logic [13:0] next_angle;
	logic [13:0] held_out;
	assign off14  = {zero_offset, 2'b00};
	// Correction spans a sixteenth turn, or an eighth when doubled
	assign corr14 = ctrl.correction_range ?
		{{2{lin_corr[10]}}, lin_corr, 1'b0} :
		{{3{lin_corr[10]}}, lin_corr};
	always_comb begin
		pre_lin  = ctrl.zero_after_lin ? angle_raw :
			angle_raw - off14;
		post_lin = ctrl.lin_enable ? pre_lin + corr14 : pre_lin;
		if (ctrl.zero_after_lin)
			post_lin = post_lin - off14;
	end
	always_ff @(posedge clk) begin
		if (!resetn)
			held_out <= 14'h0;
		else
			held_out <= hyst_step(held_out, post_lin, hyst_thr);
	end
	assign next_angle = ctrl.out_hyst_en ? held_out : post_lin;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			out_angle  <= 14'h0;
			lin_active <= 1'b0;
		end else begin
			out_angle  <= next_angle;
			lin_active <= ctrl.lin_enable;
		end
	end

	// Turns source and turns angle register
	logic [13:0] pll_held;
	logic [13:0] pll_pick;
	always_ff @(posedge clk) begin
		if (!resetn)
			pll_held <= 14'h0;
		else
			pll_held <= hyst_step(pll_held, pll_angle, hyst_thr);
	end
	assign pll_pick = ctrl.hyst_to_turn_count ? pll_held : pll_angle;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			turns_angle <= 14'h0;
			turns_in    <= 14'h0;
		end else begin
			turns_angle <= pll_pick;
			turns_in    <= turns_use_pll ? pll_pick : zcd_angle;
		end
	end

	// PWM carrier as a phase accumulator: frequency in Hz added per
	// clock, wrap at the clock rate, or twice it when err_halve is set; no divider needed for any entry
	logic [31:0] phase;
	logic [31:0] modulus;
	logic [31:0] next_phase;
	logic [31:0] duty_thr;
	logic [11:0] carrier_hz;
	logic [7:0]  duty;
	assign carrier_hz = oic_pkg::oic_pwm_hz[{ctrl.pwm_band,
		ctrl.pwm_freq_sel}];
	assign modulus = err_halve ? 32'(2 * CLK_HZ) : 32'(CLK_HZ);
	assign duty = err_halve ? err_code : out_angle[13:6];
	assign duty_thr = 32'((modulus >> `OIC_DUTY_BITS) * duty);
	always_comb begin
		next_phase = phase + {20'h00000, carrier_hz};
		if (next_phase >= modulus)
			next_phase = next_phase - modulus;
	end
	always_ff @(posedge clk) begin
		if (!resetn)
			phase <= 32'h0;
		else
			phase <= next_phase;
	end

	// Shared pin driver
	always_ff @(posedge clk) begin
		if (!resetn) begin
			miso_o  <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			unique case (out_mode)
			oic_pkg::mode_pwm: begin
				miso_o  <= phase < duty_thr;
				miso_oe <= !err_tri;
			end
			oic_pkg::mode_sent: begin
				miso_o  <= sent_tx;
				miso_oe <= 1'b1;
			end
			default: begin
				miso_o  <= spi_dout;
				miso_oe <= spi_dout_en;
			end
			endcase
		end
	end

	// SENT bus level synchroniser and idle counter
	logic       bus_m;
	logic       bus_s;
	logic [9:0] idle_cnt;
	logic       idle_hit;
	logic       resync;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bus_m <= 1'b1;
			bus_s <= 1'b1;
		end else begin
			bus_m <= sent_bus_pin;
			bus_s <= bus_m;
		end
	end
	// Saturates one past the limit so the hit fires once per idle spell
	assign idle_hit = bus_s && sent_tick &&
		idle_cnt == `OIC_IDLE_TICKS;
	always_ff @(posedge clk) begin
		if (!resetn)
			idle_cnt <= 10'h0;
		else if (!bus_s)
			idle_cnt <= 10'h0;
		else if (sent_tick && idle_cnt <= `OIC_IDLE_TICKS)
			idle_cnt <= idle_cnt + 10'h1;
	end

	// Slot counter; a shadow load counts as the reset of the slot logic
	assign resync = sync_pulse ||
		(idle_hit && ctrl.idle_slot_resync) ||
		(slot_sync && slot_mark_en);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			online   <= 1'b1;
			slot_cnt <= 4'h0;
		end else if (!shared_bus) begin
			online   <= 1'b1;
			slot_cnt <= 4'h0;
		end else if (cfg_load) begin
			online   <= !cfg_word[7];
			slot_cnt <= 4'h0;
		end else if (resync) begin
			online   <= 1'b1;
			slot_cnt <= 4'h0;
		end else if (slot_advance && online)
			slot_cnt <= slot_cnt + 4'h1;
	end

	// Manchester commands pass only when not ignored
	always_ff @(posedge clk) begin
		if (!resetn)
			man_cmd_accept <= 1'b0;
		else
			man_cmd_accept <= man_cmd_valid &&
				!ctrl.manchester_ignore;
	end

	// SPI clock and select synchronisers, rising edge count
	logic       sclk_m;
	logic       sclk_s;
	logic       sclk_d;
	logic       csn_m;
	logic       csn_s;
	logic [4:0] edge_cnt;
	logic       sclk_rise;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sclk_m <= 1'b0;
			sclk_s <= 1'b0;
			sclk_d <= 1'b0;
			csn_m  <= 1'b1;
			csn_s  <= 1'b1;
		end else begin
			sclk_m <= spi_sclk_pin;
			sclk_s <= sclk_m;
			sclk_d <= sclk_s;
			csn_m  <= spi_csn_pin;
			csn_s  <= csn_m;
		end
	end
	assign sclk_rise = sclk_s && !sclk_d && !csn_s;
	always_ff @(posedge clk) begin
		if (!resetn)
			edge_cnt <= 5'h0;
		else if (csn_s)
			edge_cnt <= 5'h0;
		else if (sclk_rise && edge_cnt != 5'h1f)
			edge_cnt <= edge_cnt + 5'h1;
	end
	// The edge numbered seventeen has sixteen already counted
	always_ff @(posedge clk) begin
		if (!resetn)
			spi_bit_strobe <= 1'b0;
		else
			spi_bit_strobe <= sclk_rise &&
				!(ctrl.skip_extra_spi_edge &&
				edge_cnt == `OIC_SKIP_EDGE - 5'h1);
	end

	// Incoming packet filter; the answer address survives a discard
	logic pkt_ok;
	assign pkt_ok = pkt.valid && (pkt.crc_ok || !ctrl.rx_crc_check);
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pkt_accept <= 1'b0;
			resp_addr  <= 6'h00;
			drop_cnt   <= 8'h00;
		end else begin
			pkt_accept <= pkt_ok;
			if (pkt_ok && pkt.is_read)
				resp_addr <= pkt.addr;
			if (pkt.valid && !pkt_ok && drop_cnt != 8'hff)
				drop_cnt <= drop_cnt + 8'h01;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_pwm_err_tri;
		out_mode == oic_pkg::mode_pwm && err_tri;
	endsequence
	sequence s_skip_edge;
		sclk_rise && ctrl.skip_extra_spi_edge && edge_cnt == 5'h10;
	endsequence

	a_pwm_owns_pin: assert property (ctrl.pwm_enable |=>
		out_mode == oic_pkg::mode_pwm && !sent_en)
		else $error("PWM enable did not take the pin");
	a_sent_variant: assert property (!ctrl.pwm_enable |=>
		sent_en == $past(sent_on))
		else $error("SENT enable does not follow variant");
	a_spi_fallback: assert property (
		out_mode == oic_pkg::mode_spi |=> miso_o == $past(spi_dout) &&
		miso_oe == $past(spi_dout_en))
		else $error("SPI data not on shared pin");
	a_err_tristate: assert property (s_pwm_err_tri |=> !miso_oe)
		else $error("PWM pin driven during error");
	a_err_ignored: assert property (
		out_mode == oic_pkg::mode_pwm && !ctrl.err_out_en |=> miso_oe)
		else $error("PWM reacted to errors while disabled");
	a_err_halve: assert property (err_halve |->
		modulus == 32'(2 * CLK_HZ) && duty == err_code)
		else $error("Error style one not halving carrier");
	a_idle_resync: assert property (shared_bus && !cfg_load &&
		idle_hit && ctrl.idle_slot_resync |=> slot_cnt == 4'h0 && online)
		else $error("Idle bus did not resync slot");
	a_offline_hold: assert property (shared_bus && cfg_load &&
		cfg_word[7] |=> !online)
		else $error("Offline hold not kept after load");
	a_online_reset: assert property (shared_bus && cfg_load &&
		!cfg_word[7] |=> online && slot_cnt == 4'h0)
		else $error("Not online at slot zero after load");
	a_man_ignore: assert property (
		ctrl.manchester_ignore && !cfg_load |=> !man_cmd_accept)
		else $error("Manchester command passed while ignored");
	a_skip_edge: assert property (s_skip_edge |=> !spi_bit_strobe)
		else $error("Seventeenth SPI edge not skipped");
	a_crc_drop: assert property (ctrl.rx_crc_check && pkt.valid &&
		!pkt.crc_ok |=> !pkt_accept && $stable(resp_addr))
		else $error("Corrupt packet accepted");
endmodule

// >>> testbench/oic_host.sv
// Host controller model: clocks SPI frames and holds the SENT bus.
// Assumes it runs on the bench clock; frame length set per request.
`timescale 1ns/1ps
module oic_host (
	// Clock
	input  wire logic       clk,
	// Frame request
	input  wire logic       go,
	input  wire logic [4:0] n_edges,
	input  wire logic       talk,
	// Pins toward the device
	output logic            sclk,
	output logic            csn,
	output logic            sent_bus,
	output logic            busy
);
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		busy = 1'b0;
	end
	// Slow frames; clock stands low outside them, 17th edge allowed
	always @(posedge clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			csn <= 1'b0;
			repeat (4) @(posedge clk);
			for (int i = 0; i < n_edges; i++) begin
				sclk <= 1'b1;
				repeat (4) @(posedge clk);
				sclk <= 1'b0;
				repeat (4) @(posedge clk);
			end
			csn <= 1'b1;
			busy <= 1'b0;
		end
	end
	// Pull-up keeps the bus idle high unless another node talks
	assign sent_bus = talk ? 1'b0 : 1'b1;
endmodule

// >>> testbench/tb_top.sv
// Self-checking bench for the output interface control block.
// Assumes the package and constants header are compiled first.
`timescale 1ns/1ps
`include "oic_consts.svh"
module tb_top;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]        adr = 8'h00;
	logic [31:0]       wdat = 32'h0, rdat, seed = 32'h7;
	logic              ack, cfg_load = 1'b0, tick = 1'b0, man = 1'b0;
	logic [25:0]       cfg_word = 26'h0;
	logic [3:0]        variant = 4'h0, slot_cnt;
	logic [7:0]        err = 8'h00;
	logic [159:0]      misc;
	oic_pkg::oic_pkt_t pkt = '0;
	logic              miso_o, miso_oe, sent_en, online, man_acc, strobe;
	logic              pkt_acc, sclk, csn, sbus, busy, go = 1'b0;
	logic              cnt_en = 1'b0, prev_miso = 1'b0;
	logic [2:0]        sent_slew;
	logic [5:0]        resp_addr;
	logic [4:0]        n_edges = 5'h11;
	logic              talk = 1'b0, sync = 1'b0, slot_adv = 1'b0, lin;
	logic [13:0]       ang, tang, tin;
	int                err_total = 0, compares = 0, strobes, edges;
	logic [31:0]       exp_q[$], msk_q[$];

	oic_top #(.CLK_HZ(65536), .N_ERR(8)) dut (.clk(clk), .resetn(resetn),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cfg_load(cfg_load), .cfg_word(cfg_word), .angle_raw(misc[13:0]),
		.pll_angle(misc[27:14]), .zcd_angle(misc[41:28]),
		.turns_use_pll(misc[42]), .hyst_thr(misc[48:43]),
		.zero_offset(misc[60:49]), .lin_corr(misc[71:61]),
		.sent_variant(variant), .sent_tx(misc[72]), .sent_tick(tick),
		.sent_bus_pin(sbus), .sync_pulse(sync), .slot_sync(1'b0),
		.slot_mark_en(misc[73]), .slot_advance(slot_adv), .err_flags(err),
		.err_duty(misc[139:76]), .spi_dout(misc[74]),
		.spi_dout_en(misc[75]), .spi_sclk_pin(sclk), .spi_csn_pin(csn),
		.pkt(pkt), .man_cmd_valid(man), .miso_o(miso_o),
		.miso_oe(miso_oe), .sent_en(sent_en), .sent_slew(sent_slew),
		.lin_active(lin), .out_angle(ang), .turns_angle(tang),
		.turns_in(tin),
		.online(online), .slot_cnt(slot_cnt), .man_cmd_accept(man_acc),
		.spi_bit_strobe(strobe), .pkt_accept(pkt_acc),
		.resp_addr(resp_addr));
	oic_host host (.clk(clk), .go(go), .n_edges(n_edges), .talk(talk),
		.sclk(sclk), .csn(csn), .sent_bus(sbus), .busy(busy));

	// Free-running 200 MHz clock
	always #2.5 clk = ~clk;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Classic cycle; ack is waited for, never assumed
	task automatic wb(input logic w, input logic [7:0] a, input [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) err_total++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input [7:0] a, input [31:0] e, input [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		wb(1'b0, a, 32'h0);
	endtask

	task automatic mode_case(input [31:0] c, input [3:0] v, input logic s,
		input [1:0] m);
		@(posedge clk);
		variant <= v;
		wb(1'b1, `OIC_ADR_CTRL, c);
		step(4);
		cmp(sent_en, s);
		rd(`OIC_ADR_STAT, m, 32'h3);
	endtask

	task automatic send(input logic ok, input [5:0] a, input logic acc);
		@(posedge clk);
		pkt <= {1'b1, ok, 1'b1, a};
		@(posedge clk);
		pkt <= '0;
		#1 cmp(pkt_acc, acc);
		step(1);
	endtask

	task automatic frame(input [31:0] exp);
		strobes = 0;
		@(posedge clk);
		go <= 1'b1;
		step(2);
		go <= 1'b0;
		for (int i = 0; i < 400 && busy; i++) step(1);
		step(8);
		cmp(strobes, exp);
	endtask

	task automatic count_edges(input [31:0] ctl, input [31:0] lo);
		wb(1'b1, `OIC_ADR_CTRL, ctl);
		step(8);
		edges = 0;
		cnt_en = 1'b1;
		step(8192);
		cnt_en = 1'b0;
		cmp((edges == lo + 1) ? lo : edges, lo);
	endtask

	// Read data is matched with the oldest note in issue order
	always @(posedge clk) begin
		prev_miso <= miso_o;
		if (strobe === 1'b1) strobes <= strobes + 1;
		if (cnt_en && miso_o && !prev_miso) edges <= edges + 1;
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
			cmp(rdat & msk_q.pop_front(), exp_q.pop_front());
	end

	// Watchdog sized well past the longest expected run
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		end_sim();
	end

	initial begin
		logic [31:0] v;
		logic [13:0] a0, c0, p0;
		misc = {xs(), xs(), xs(), xs(), xs()};
		misc[83:76] = 8'h80;
		misc[48:42] = 7'h21; // Threshold 16, turns from PLL angle
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		step(1);
		cmp(sent_slew, 32'h0);
		rd(`OIC_ADR_CTRL, 32'h0, 32'hffffffff);
		rd(8'h40, 32'h0, 32'hffffffff);
		for (int i = 0; i < 4; i++) begin
			v = xs() & 32'h037f7fff;
			wb(1'b1, `OIC_ADR_CTRL, v);
			rd(`OIC_ADR_CTRL, v, 32'hffffffff);
			step(1);
			cmp(sent_slew, v[6:4]);
		end
		// Angle path: correction range, hysteresis, turns source
		a0 = misc[13:0] - {misc[60:49], 2'b00};
		c0 = {{3{misc[71]}}, misc[71:61]};
		p0 = misc[27:14];
		wb(1'b1, `OIC_ADR_CTRL, 32'h800);
		step(3);
		cmp(ang, 14'(a0 + c0));
		cmp(lin, 32'h1);
		wb(1'b1, `OIC_ADR_CTRL, 32'he00);
		step(3);
		cmp(ang, 14'(a0 + {c0[12:0], 1'b0}));
		wb(1'b1, `OIC_ADR_CTRL, 32'h4004);
		misc[27:0] <= {misc[27:14] + 14'h2000, misc[13:0] + 14'h2000};
		step(3);
		cmp(ang, 14'(a0 + 14'h2000));
		cmp(tang, 14'(p0 + 14'h2000));
		@(posedge clk);
		misc[27:0] <= {misc[27:14] + 14'h1, misc[13:0] + 14'h1};
		step(3);
		cmp(ang, 14'(a0 + 14'h2000));
		cmp(tin, 14'(p0 + 14'h2000));
		wb(1'b1, `OIC_ADR_CTRL, 32'h0);
		step(3);
		cmp(ang, 14'(a0 + 14'h2001));
		cmp(tang, 14'(p0 + 14'h2001));
		cmp(lin, 32'h0);
		@(posedge clk);
		misc[42] <= 1'b0;
		step(3);
		cmp(tin, misc[41:28]);
		mode_case(32'h800000, 4'h6, 1'b0, 2'h3);
		cmp(miso_oe, 32'h1);
		mode_case(32'h0, 4'h6, 1'b1, 2'h1);
		mode_case(32'h0, 4'h0, 1'b0, 2'h0);
		cmp({miso_oe, miso_o}, {misc[75], misc[74]});
		// Error reaction of the pwm pin
		err <= 8'h01;
		mode_case(32'h802000, 4'h0, 1'b0, 2'h3);
		cmp(miso_oe, 32'h0);
		mode_case(32'h800000, 4'h0, 1'b0, 2'h3);
		cmp(miso_oe, 32'h1);
		count_edges(32'h803000, 32'd195);
		count_edges(32'hff3000, 32'd6);
		err <= 8'h00;
		// Manchester commands; accept stands one cycle after the pulse
		wb(1'b1, `OIC_ADR_CTRL, 32'h8);
		man <= 1'b1;
		@(posedge clk);
		man <= 1'b0;
		#1 cmp(man_acc, 32'h0);
		wb(1'b1, `OIC_ADR_CTRL, 32'h0);
		man <= 1'b1;
		@(posedge clk);
		man <= 1'b0;
		#1 cmp(man_acc, 32'h1);
		// Packets with and without the incoming check
		send(1'b0, 6'h05, 1'b1);
		wb(1'b1, `OIC_ADR_CTRL, 32'h1);
		send(1'b1, 6'h09, 1'b1);
		send(1'b0, 6'h0c, 1'b0);
		cmp(resp_addr, 32'h09);
		rd(`OIC_ADR_STAT, 32'h100, 32'hff00);
		// Frames of seventeen edges, skip off then on
		wb(1'b1, `OIC_ADR_CTRL, 32'h0);
		frame(32'd17);
		wb(1'b1, `OIC_ADR_CTRL, 32'h2);
		frame(32'd16);
		// Shared-bus slot logic after a slot reset
		@(posedge clk);
		variant <= 4'h6;
		cfg_word <= 26'h0;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		step(2);
		cmp({online, slot_cnt}, 32'h10);
		cfg_word <= 26'h180;
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		step(2);
		cmp(online, 32'h0);
		// A busy bus part way restarts the idle count
		tick <= 1'b1;
		step(300);
		talk <= 1'b1;
		step(4);
		talk <= 1'b0;
		step(513);
		cmp(online, 32'h0);
		step(1);
		cmp({online, slot_cnt}, 32'h10);
		slot_adv <= 1'b1;
		@(posedge clk);
		slot_adv <= 1'b0;
		#1 cmp(slot_cnt, 32'h1);
		// Offline again, then a sync pulse brings it back at slot zero
		cfg_load <= 1'b1;
		@(posedge clk);
		cfg_load <= 1'b0;
		step(3);
		cmp({online, slot_cnt}, 32'h0);
		sync <= 1'b1;
		@(posedge clk);
		sync <= 1'b0;
		#1 cmp({online, slot_cnt}, 32'h10);
		tick <= 1'b0;
		step(4);
		end_sim();
	end
endmodule
